// ### pkg/cpmc_if.sv
// register port between the controller and the clock unit
interface cpmc_if;
	logic req;
	logic we;
	logic [3:0] addr;
	logic [31:0] wdata;
	logic ready;
	logic [31:0] rdata;
	modport dev (input req, input we, input addr, input wdata, output ready, output rdata);
	modport ctl (output req, output we, output addr, output wdata, input ready, input rdata);
endinterface : cpmc_if

// ### pkg/cpmc_pkg.sv
// shared constants and types of the clock and power mode control
package cpmc_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_KHZ = 50000;
	localparam int unsigned PLL_SETTLE_US = 100;
	localparam int unsigned PLL_SETTLE_CYC = (PLL_SETTLE_US * CLK_KHZ + 999) / 1000;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned IRC_KHZ = 12000;
	localparam int unsigned CCO_MIN_KHZ = 156000;
	localparam int unsigned CCO_MAX_KHZ = 320000;
	localparam int unsigned OUT_MAX_KHZ = 100000;
	localparam int unsigned PLL_M_MAX = 32;
	localparam int unsigned N_WAKE = 12;
	// ------------------------------------------------------------
	// device register indexes
	// ------------------------------------------------------------
	localparam logic [3:0] RA_MAINSEL = 4'h0;
	localparam logic [3:0] RA_PLLCFG = 4'h1;
	localparam logic [3:0] RA_PLLPWR = 4'h2;
	localparam logic [3:0] RA_STAT = 4'h3;
	localparam logic [3:0] RA_OUTSEL = 4'h4;
	localparam logic [3:0] RA_GATE = 4'h5;
	localparam logic [3:0] RA_CPUDIV = 4'h6;
	localparam logic [3:0] RA_PMODE = 4'h7;
	localparam logic [3:0] RA_DSCFG = 4'h8;
	localparam logic [3:0] RA_STARTEN = 4'h9;
	localparam logic [1:0] RA_GP_HI = 2'h3;
	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int unsigned PLL_M_LSB = 0;
	localparam int unsigned PLL_P_LSB = 5;
	localparam int unsigned PLL_REF_BIT = 7;
	localparam int unsigned OUT_WD_BIT = 2;
	localparam int unsigned DS_KEEP_WD = 0;
	localparam int unsigned DS_KEEP_BOD = 1;
	localparam int unsigned STAT_LOCK = 0;
	localparam int unsigned STAT_SWBUSY = 1;
	localparam logic [7:0] CPUDIV_RST = 8'h01;
	localparam int unsigned PW_IRC = 0;
	localparam int unsigned PW_SYS = 1;
	localparam int unsigned PW_WD = 2;
	localparam int unsigned PW_BOD = 3;
	localparam int unsigned PW_PLL = 4;
	localparam int unsigned PW_CORE = 5;
	typedef enum logic [1:0] {SRC_IRC = 2'h0, SRC_SYSOSC = 2'h1, SRC_WDOSC = 2'h2,
		SRC_PLL = 2'h3} cpmc_src_t;
	typedef enum logic [1:0] {PM_RUN = 2'h0, PM_SLEEP = 2'h1, PM_DSLEEP = 2'h2,
		PM_DPD = 2'h3} cpmc_pm_t;
	// ------------------------------------------------------------
	// controller apb map and commands
	// ------------------------------------------------------------
	localparam logic [7:0] AO_ADDR = 8'h00;
	localparam logic [7:0] AO_DATA = 8'h04;
	localparam logic [7:0] AO_CMD = 8'h08;
	localparam logic [7:0] AO_STATUS = 8'h0c;
	typedef enum logic [1:0] {CMD_WR = 2'h0, CMD_RD = 2'h1, CMD_PLLUP = 2'h2,
		CMD_DSLEEP = 2'h3} cpmc_cmd_t;
endpackage : cpmc_pkg

// ### rtl/cpmc_ctl.sv
// controller: apb registers and sequencer driving the clock unit
module cpmc_ctl #(
	parameter int unsigned SYSOSC_KHZ = 12000
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// clock unit port
	cpmc_if.ctl dev
);
	import cpmc_pkg::*;

	if (SYSOSC_KHZ < 1000 || SYSOSC_KHZ > 25000) begin : g_chk
		$error("cpmc_ctl: crystal frequency out of range");
	end

	typedef enum logic [1:0] {C_IDLE = 2'h0, C_ISSUE = 2'h1, C_WAIT = 2'h2} cpmc_cst_t;
	typedef enum logic [2:0] {OP_WR = 3'h0, OP_RD = 3'h1, OP_POLL1 = 3'h2, OP_POLL0 = 3'h3,
		OP_NOP = 3'h4, OP_END = 3'h5} cpmc_opk_t;
	typedef struct packed {
		cpmc_opk_t kind;
		logic [3:0] addr;
		logic [31:0] data;
	} cpmc_op_t;
	typedef struct packed {
		cpmc_cst_t st;
		cpmc_cmd_t cmd;
		logic [2:0] step;
		logic [3:0] aaddr;
		logic [31:0] adata;
		logic [31:0] rd;
		logic err;
		logic req;
		logic we;
		logic [3:0] addr;
		logic [31:0] wd;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} cpmc_ctl_t;

	localparam logic [31:0] LOCK_MASK = 32'h1 << STAT_LOCK;
	localparam logic [31:0] SWBUSY_MASK = 32'h1 << STAT_SWBUSY;

	// loop and output frequencies of the requested setting
	function automatic logic pll_ok(input logic [31:0] a);
		logic [31:0] fin;
		logic [31:0] fout;
		logic [31:0] fcco;
		fin = a[PLL_REF_BIT] ? 32'(SYSOSC_KHZ) : 32'(IRC_KHZ);
		fcco = fin * (32'(a[PLL_M_LSB +: 5]) + 32'h1);
		fout = fcco >> (a[PLL_P_LSB +: 2] + 3'h1);
		return fcco >= CCO_MIN_KHZ && fcco <= CCO_MAX_KHZ && fout < OUT_MAX_KHZ; // R7
	endfunction : pll_ok

	// step table of each command
	function automatic cpmc_op_t step_op(input cpmc_cmd_t c, input logic [2:0] s,
		input logic [3:0] a, input logic [31:0] d);
		cpmc_op_t o;
		o = '{OP_END, 4'h0, 32'h0};
		case (c)
			CMD_WR: if (s == 3'h0) o = '{OP_WR, a, d};
			CMD_RD: if (s == 3'h0) o = '{OP_RD, a, 32'h0};
			CMD_PLLUP: begin
				case (s)
					3'h0: o = '{OP_WR, RA_PLLCFG, d}; // R5
					3'h1: o = '{OP_WR, RA_PLLPWR, 32'h1};
					3'h2: o = '{OP_POLL1, RA_STAT, LOCK_MASK}; // R5 R6
					3'h3: o = '{OP_WR, RA_MAINSEL, 32'(SRC_PLL)};
					3'h4: o = '{OP_POLL0, RA_STAT, SWBUSY_MASK};
					default: o = '{OP_END, 4'h0, 32'h0};
				endcase
			end
			default: begin
				case (s)
					3'h0: o = '{OP_RD, RA_STARTEN, 32'h0}; // R21
					3'h1: o = '{OP_WR, RA_DSCFG, d};
					// rc starts and stops cleanly unless watchdog osc stays on
					3'h2: o = '{cpmc_opk_t'(d[DS_KEEP_WD] ? OP_NOP : OP_WR), RA_MAINSEL,
						32'(SRC_IRC)}; // R18
					3'h3: o = '{OP_POLL0, RA_STAT, SWBUSY_MASK}; // R18
					3'h4: o = '{OP_WR, RA_PMODE, 32'(PM_DSLEEP)};
					default: o = '{OP_END, 4'h0, 32'h0};
				endcase
			end
		endcase
		return o;
	endfunction : step_op

	cpmc_ctl_t r_reg;
	cpmc_ctl_t r_next;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		cpmc_op_t op;
		logic busy;
		logic hit;
		r_next = r_reg;
		hit = 1'b1;
		busy = r_reg.st != C_IDLE;
		op = step_op(r_reg.cmd, r_reg.step, r_reg.aaddr, r_reg.adata);
		// apb: answer in the first access cycle
		r_next.pready = 1'b0;
		r_next.pslverr = 1'b0;
		if (psel && !penable && !r_reg.pready) begin
			r_next.pready = 1'b1;
			case (paddr)
				AO_ADDR: r_next.prdata = 32'(r_reg.aaddr);
				AO_DATA: r_next.prdata = busy ? r_reg.adata : r_reg.rd;
				AO_CMD: r_next.prdata = 32'(r_reg.cmd);
				AO_STATUS: r_next.prdata = 32'({r_reg.err, busy});
				default: begin
					r_next.prdata = 32'h0;
					hit = 1'b0;
				end
			endcase
			r_next.pslverr = ~hit;
		end
		if (psel && penable && r_reg.pready && pwrite) begin
			if (busy) begin
				// arguments are frozen while a command runs
				r_next.err = r_reg.err | (paddr == AO_CMD);
			end else begin
				case (paddr)
					AO_ADDR: r_next.aaddr = pwdata[3:0];
					AO_DATA: r_next.adata = pwdata;
					AO_CMD: begin
						r_next.cmd = cpmc_cmd_t'(pwdata[1:0]);
						r_next.step = 3'h0;
						r_next.err = 1'b0;
						r_next.st = C_ISSUE;
						if (pwdata[1:0] == CMD_PLLUP && !pll_ok(r_reg.adata)) begin
							r_next.err = 1'b1; // R7
							r_next.st = C_IDLE;
						end
					end
					default: begin
					end
				endcase
			end
		end
		// ------------------------------------------------------------
		// sequencer
		// ------------------------------------------------------------
		case (r_reg.st)
			C_ISSUE: begin
				if (op.kind == OP_END) begin
					r_next.st = C_IDLE;
				end else if (op.kind == OP_NOP) begin
					r_next.step = r_reg.step + 3'h1;
				end else begin
					r_next.req = 1'b1;
					r_next.we = op.kind == OP_WR;
					r_next.addr = op.addr;
					r_next.wd = op.data;
					r_next.st = C_WAIT;
				end
			end
			C_WAIT: begin
				if (dev.ready) begin
					r_next.req = 1'b0;
					r_next.we = 1'b0;
					r_next.st = C_ISSUE;
					if (op.kind != OP_WR) begin
						r_next.rd = dev.rdata;
					end
					case (op.kind)
						OP_POLL1: if ((dev.rdata & op.data) != 32'h0) r_next.step = r_reg.step + 3'h1;
						OP_POLL0: if ((dev.rdata & op.data) == 32'h0) r_next.step = r_reg.step + 3'h1;
						default: r_next.step = r_reg.step + 3'h1;
					endcase
					// no wake source enabled: refuse to go to deep-sleep
					if (r_reg.cmd == CMD_DSLEEP && r_reg.step == 3'h0
						&& dev.rdata[N_WAKE-1:0] == '0) begin
						r_next.err = 1'b1; // R21
						r_next.st = C_IDLE;
					end
				end
			end
			C_IDLE: begin
			end
			default: begin
				r_next.st = C_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata = r_reg.prdata;
	assign pready = r_reg.pready;
	assign pslverr = r_reg.pslverr;
	assign dev.req = r_reg.req;
	assign dev.we = r_reg.we;
	assign dev.addr = r_reg.addr;
	assign dev.wdata = r_reg.wd;
endmodule : cpmc_ctl

// ### rtl/cpmc_dev.sv
// clock unit: source mux, pll, clock output, gating, divider, power modes
// Summary of operation
// [R1] reset selects internal rc oscillator as source
// [R2] pll multiplier setting 1 to 32
// [R3] pll output divider 2, 4, 8, 16
// [R4] pll off and bypassed after reset
// [R5] software locks pll before switching to it
// [R6] pll lock only after 100 us settling
// [R7] software keeps loop and output frequencies legal
// [R8] crystal selectable directly or as pll reference
// [R9] rc oscillator drives watchdog or pll reference
// [R10] watchdog oscillator drives cpu, watchdog, clock pin
// [R11] clock pin picks one of four sources
// [R12] per-peripheral clock gate register
// [R13] programmable cpu clock divider
// [R14] sleep stops core clock until interrupt
// [R15] peripheral clocks keep running in sleep
// [R16] deep-sleep powers analog off, optional keeps
// [R17] deep-sleep exit on wake pins or rtc
// [R18] software switches to rc before deep-sleep; the controller skips the switch when DS_KEEP_WD is set
// [R19] deep power-down keeps only retention registers
// [R20] deep power-down exit resumes on rc oscillator
// [R21] software configures start logic before relying on it
// [R22] source switch without truncated or glitched pulses
//
// The APB register port and the placing of the registers were chosen for this implementation.
module cpmc_dev #(
	parameter int unsigned N_PERIPH = 16,
	parameter int unsigned SETTLE_CYC = cpmc_pkg::PLL_SETTLE_CYC
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// register port
	cpmc_if.dev bus,
	// oscillator edges, one-cycle pulses
	input wire logic irc_tick_i,
	input wire logic sysosc_tick_i,
	input wire logic wdosc_tick_i,
	// wake sources
	input wire logic irq_i,
	input wire logic [cpmc_pkg::N_WAKE-1:0] wake_pin_i,
	input wire logic rtc_match_i,
	input wire logic powerdown_exit_pin_n_i,
	// generated clock edges
	output logic main_tick_o,
	output logic cpu_core_clock_o,
	output logic clock_output_pin_o,
	output logic watchdog_counter_tick_o,
	output logic [N_PERIPH-1:0] periph_clk_en_o,
	// power switches
	output logic [5:0] power_en_o,
	output logic [3:0][31:0] retention_o
);
	import cpmc_pkg::*;

	if (N_PERIPH < 1 || N_PERIPH > 32 || SETTLE_CYC < 1 || SETTLE_CYC >= 2 ** CNT_W) begin : g_chk
		$error("cpmc_dev: parameter out of range");
	end

	typedef enum logic [1:0] {SW_RUN = 2'h0, SW_DRAIN = 2'h1, SW_NEW = 2'h2} cpmc_sw_t;
	typedef struct packed {
		cpmc_src_t src;
		cpmc_src_t tgt;
		cpmc_sw_t sw;
		logic [7:0] pllcfg;
		logic pll_on;
		logic lock;
		logic [CNT_W-1:0] settle;
		logic [3:0] pcnt;
		logic [2:0] outsel;
		logic [N_PERIPH-1:0] gate;
		logic [7:0] cpudiv;
		logic [7:0] dcnt;
		cpmc_pm_t pm;
		logic [1:0] ds;
		logic [N_WAKE-1:0] starten;
		logic [3:0][31:0] gp;
		logic ready;
		logic [31:0] rdata;
		logic main_tick;
		logic cpu_tick;
		logic out_tick;
		logic wdt_tick;
		logic [N_PERIPH-1:0] pen;
		logic [5:0] pwr;
	} cpmc_dev_t;

	localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

	// ------------------------------------------------------------
	// reset state
	// ------------------------------------------------------------
	function automatic cpmc_dev_t defaults();
		cpmc_dev_t d;
		d = '0;
		d.src = SRC_IRC; // R1
		d.tgt = SRC_IRC;
		d.pll_on = 1'b0; // R4
		d.cpudiv = CPUDIV_RST;
		d.gate = '1;
		d.pwr = 6'h0;
		d.pwr[PW_IRC] = 1'b1;
		d.pwr[PW_SYS] = 1'b1;
		d.pwr[PW_WD] = 1'b1;
		d.pwr[PW_BOD] = 1'b1;
		d.pwr[PW_CORE] = 1'b1;
		return d;
	endfunction : defaults

	cpmc_dev_t r_reg;
	cpmc_dev_t r_next;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic irc_t;
		logic sys_t;
		logic wd_t;
		logic ref_t;
		logic pll_t;
		logic pll_run;
		logic main_t;
		logic deep;
		logic [1:0] psel;
		logic [3:0] pmax;
		logic [3:0] src_t;
		irc_t = irc_tick_i & r_reg.pwr[PW_IRC];
		sys_t = sysosc_tick_i & r_reg.pwr[PW_SYS];
		wd_t = wdosc_tick_i & r_reg.pwr[PW_WD];
		r_next = r_reg;
		// crystal or rc feeds the pll reference
		ref_t = r_reg.pllcfg[PLL_REF_BIT] ? sys_t : irc_t; // R8 R9
		psel = r_reg.pllcfg[PLL_P_LSB +: 2];
		pmax = 4'((5'h02 << psel) - 5'h01); // R3
		// loop oscillator modelled by the system clock; the multiplier is analog
		pll_run = r_reg.pll_on & r_reg.lock & r_reg.pwr[PW_PLL]; // R2
		pll_t = pll_run ? (r_reg.pcnt == pmax) : ref_t; // R4
		if (pll_run && r_reg.pcnt != pmax) begin
			r_next.pcnt = r_reg.pcnt + 4'h1;
		end else begin
			r_next.pcnt = 4'h0;
		end
		// lock flag cannot rise before the settling count expires
		if (!(r_reg.pll_on && r_reg.pwr[PW_PLL])) begin
			r_next.settle = '0;
			r_next.lock = 1'b0;
		end else if (r_reg.settle == SETTLE_LAST) begin
			r_next.lock = 1'b1; // R6
		end else begin
			r_next.settle = r_reg.settle + CNT_W'(1);
		end
		src_t = {pll_t, wd_t, sys_t, irc_t}; // R8 R10
		// finish the old period, stay low, start on a new-source edge
		main_t = 1'b0;
		case (r_reg.sw)
			SW_RUN: begin
				main_t = src_t[r_reg.src];
			end
			SW_DRAIN: begin
				main_t = src_t[r_reg.src];
				if (main_t) begin
					r_next.sw = SW_NEW; // R22
				end
			end
			SW_NEW: begin
				main_t = src_t[r_reg.tgt];
				if (main_t) begin
					r_next.src = r_reg.tgt; // R22
					r_next.sw = SW_RUN;
				end
			end
			default: begin
				r_next.sw = SW_RUN;
			end
		endcase
		r_next.main_tick = main_t;
		// divide by cpudiv; zero stops the core clock
		r_next.cpu_tick = 1'b0;
		if (main_t) begin
			if (r_reg.dcnt >= r_reg.cpudiv - 8'h01) begin
				r_next.dcnt = 8'h00;
				r_next.cpu_tick = (r_reg.cpudiv != 8'h00) && (r_reg.pm == PM_RUN); // R13 R14
			end else begin
				r_next.dcnt = r_reg.dcnt + 8'h01;
			end
		end
		case (r_reg.outsel[1:0])
			2'h0: r_next.out_tick = irc_t; // R11
			2'h1: r_next.out_tick = sys_t;
			2'h2: r_next.out_tick = wd_t;
			default: r_next.out_tick = main_t;
		endcase
		r_next.wdt_tick = r_reg.outsel[OUT_WD_BIT] ? wd_t : irc_t; // R9 R10
		deep = (r_reg.pm == PM_DSLEEP) || (r_reg.pm == PM_DPD);
		r_next.pen = r_reg.gate & {N_PERIPH{~deep}}; // R12 R15
		// analog power follows the mode
		r_next.pwr[PW_IRC] = ~deep;
		r_next.pwr[PW_SYS] = ~deep;
		r_next.pwr[PW_PLL] = ~deep & r_reg.pll_on;
		r_next.pwr[PW_WD] = ~deep | (r_reg.pm == PM_DSLEEP && r_reg.ds[DS_KEEP_WD]); // R16
		r_next.pwr[PW_BOD] = ~deep | (r_reg.pm == PM_DSLEEP && r_reg.ds[DS_KEEP_BOD]); // R16
		r_next.pwr[PW_CORE] = (r_reg.pm != PM_DPD); // R19
		// ------------------------------------------------------------
		// register port, one-cycle answer
		// ------------------------------------------------------------
		r_next.ready = 1'b0;
		if (bus.req && !r_reg.ready) begin
			r_next.ready = 1'b1;
			r_next.rdata = 32'h0;
			if (bus.addr[3:2] == RA_GP_HI) begin
				r_next.rdata = r_reg.gp[bus.addr[1:0]];
			end else begin
				case (bus.addr)
					RA_MAINSEL: r_next.rdata = 32'(r_reg.src);
					RA_PLLCFG: r_next.rdata = 32'(r_reg.pllcfg);
					RA_PLLPWR: r_next.rdata = 32'(r_reg.pll_on);
					RA_STAT: r_next.rdata = 32'({r_reg.pm, r_reg.src, r_reg.sw != SW_RUN,
						r_reg.lock});
					RA_OUTSEL: r_next.rdata = 32'(r_reg.outsel);
					RA_GATE: r_next.rdata = 32'(r_reg.gate);
					RA_CPUDIV: r_next.rdata = 32'(r_reg.cpudiv);
					RA_PMODE: r_next.rdata = 32'(r_reg.pm);
					RA_DSCFG: r_next.rdata = 32'(r_reg.ds);
					RA_STARTEN: r_next.rdata = 32'(r_reg.starten);
					default: r_next.rdata = 32'h0;
				endcase
			end
			if (bus.we) begin
				if (bus.addr[3:2] == RA_GP_HI) begin
					r_next.gp[bus.addr[1:0]] = bus.wdata;
				end
				case (bus.addr)
					RA_MAINSEL: begin
						// a request during a switch is dropped
						if (r_reg.sw == SW_RUN && bus.wdata[1:0] != r_reg.src) begin
							r_next.tgt = cpmc_src_t'(bus.wdata[1:0]);
							r_next.sw = SW_DRAIN;
						end
					end
					RA_PLLCFG: begin
						r_next.pllcfg = bus.wdata[7:0]; // R2 R3
						r_next.lock = 1'b0;
						r_next.settle = '0;
					end
					RA_PLLPWR: r_next.pll_on = bus.wdata[0];
					RA_OUTSEL: r_next.outsel = bus.wdata[2:0];
					RA_GATE: r_next.gate = bus.wdata[N_PERIPH-1:0]; // R12
					RA_CPUDIV: r_next.cpudiv = bus.wdata[7:0]; // R13
					RA_PMODE: r_next.pm = cpmc_pm_t'(bus.wdata[1:0]);
					RA_DSCFG: r_next.ds = bus.wdata[1:0];
					RA_STARTEN: r_next.starten = bus.wdata[N_WAKE-1:0];
					default: begin
					end
				endcase
			end
		end
		// ------------------------------------------------------------
		// wake-up, overrides a mode write in the same cycle; deep power-down exit overrides any write
		// ------------------------------------------------------------
		case (r_reg.pm)
			PM_SLEEP: begin
				if (irq_i) begin
					r_next.pm = PM_RUN; // R14
				end
			end
			PM_DSLEEP: begin
				if (|(wake_pin_i & r_reg.starten) || rtc_match_i) begin
					r_next.pm = PM_RUN; // R17
				end
			end
			PM_DPD: begin
				if (!powerdown_exit_pin_n_i || rtc_match_i) begin
					r_next = defaults(); // R20
					r_next.gp = r_reg.gp; // R19
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			r_reg <= defaults(); // R1 R4
		end else begin
			r_reg <= r_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign bus.ready = r_reg.ready;
	assign bus.rdata = r_reg.rdata;
	assign main_tick_o = r_reg.main_tick;
	assign cpu_core_clock_o = r_reg.cpu_tick;
	assign clock_output_pin_o = r_reg.out_tick;
	assign watchdog_counter_tick_o = r_reg.wdt_tick;
	assign periph_clk_en_o = r_reg.pen;
	assign power_en_o = r_reg.pwr;
	assign retention_o = r_reg.gp;
endmodule : cpmc_dev

// ### tb/cpmc_port_asserts.sv
// assertions on the register port between controller and clock unit
module cpmc_port_asserts
	import cpmc_pkg::*;
#(
	parameter int unsigned SETTLE_CYC = 20
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// register port
	input wire logic req,
	input wire logic we,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic ready,
	input wire logic [31:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);
	// --------------------------------
	// request tracking
	// --------------------------------
	// taken request, kept while req drops
	logic t_we, wr_done, rd_done, rd_stat;
	logic [3:0] t_addr;
	logic [31:0] t_wd, current_controlled_osc;
	logic [15:0] cnt_reg;
	logic lock_reg, nz_reg, keep_reg, irc_reg, sw_reg;
	assign wr_done = ready && t_we;
	assign rd_done = ready && !t_we;
	assign rd_stat = rd_done && t_addr == RA_STAT;
	assign current_controlled_osc = IRC_KHZ * (32'(t_wd[4:0]) + 32'd1);
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			t_we <= 1'b0;
			t_addr <= 4'h0;
			t_wd <= 32'h0;
			cnt_reg <= 16'h0;
			lock_reg <= 1'b0;
			nz_reg <= 1'b0;
			keep_reg <= 1'b0;
			irc_reg <= 1'b1;
			sw_reg <= 1'b1;
		end else begin
			if (req && !ready) begin
				t_we <= we;
				t_addr <= addr;
				t_wd <= wdata;
			end
			if (wr_done && t_addr == RA_PLLPWR) cnt_reg <= 16'h0;
			else if (cnt_reg != 16'hffff) cnt_reg <= cnt_reg + 16'h1;
			if (rd_stat && rdata[STAT_LOCK]) lock_reg <= 1'b1;
			else if (wr_done && (t_addr == RA_PLLCFG || t_addr == RA_PLLPWR)) lock_reg <= 1'b0;
			if (rd_done && t_addr == RA_STARTEN) nz_reg <= (rdata[11:0] != 12'h0);
			if (wr_done && t_addr == RA_DSCFG) keep_reg <= t_wd[DS_KEEP_WD];
			if (wr_done && t_addr == RA_MAINSEL) irc_reg <= (t_wd[1:0] == SRC_IRC);
			if (wr_done && t_addr == RA_MAINSEL) sw_reg <= 1'b0;
			else if (rd_stat && !rdata[STAT_SWBUSY]) sw_reg <= 1'b1;
		end
	end
	// --------------------------------
	// checks
	// --------------------------------
	sequence s_answer;
		ready ##1 !ready;
	endsequence
	sequence s_ds_entry;
		wr_done && t_addr == RA_PMODE && t_wd[1:0] == PM_DSLEEP;
	endsequence
	a_answer_once: assert property (req && !ready |=> s_answer)
		else $error("register port answer not exactly one cycle");
	a_no_spurious: assert property (!req |=> !ready)
		else $error("answer without request");
	a_lock_settle: assert property (rd_stat && rdata[STAT_LOCK] |-> cnt_reg >= SETTLE_CYC)
		else $error("lock reported before settling time");
	a_mainsel_lock: assert property (
		wr_done && t_addr == RA_MAINSEL && t_wd[1:0] == SRC_PLL |-> lock_reg)
		else $error("switch to pll without seen lock");
	a_pllcfg_legal: assert property (wr_done && t_addr == RA_PLLCFG |->
		current_controlled_osc >= CCO_MIN_KHZ && current_controlled_osc <= CCO_MAX_KHZ && current_controlled_osc < (OUT_MAX_KHZ << (t_wd[6:5] + 3'd1)))
		else $error("pll setting out of range");
	a_ds_irc: assert property (s_ds_entry |-> keep_reg || irc_reg)
		else $error("deep-sleep entered off the rc oscillator");
	a_ds_start: assert property (s_ds_entry |-> nz_reg)
		else $error("deep-sleep entered with no wake source");
	a_ds_switched: assert property (s_ds_entry |-> sw_reg)
		else $error("deep-sleep entered during a source switch");
endmodule : cpmc_port_asserts

// ### tb/tb_top.sv
// self-checking bench joining controller and clock unit
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cpmc_pkg::*;
	localparam int unsigned SETTLE = 20;
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} cpmc_exp_t;
	logic clock_i, srst_i, psel, penable, pwrite, pready, pslverr, chk_on;
	logic irc_tick_i, sysosc_tick_i, wdosc_tick_i, irq_i, rtc_match_i, pd_exit_n;
	logic main_tick, cpu_tick;
	logic [7:0] paddr;
	logic [11:0] wake_pin_i;
	logic [15:0] pclk_en;
	logic [5:0] power_en;
	logic [31:0] pwdata, prdata, tk, rv, g;
	int fail_count, check_count, cpu_cnt, main_cnt, dc, dm;
	cpmc_exp_t exp_q[$];
	cpmc_if port_if();
	cpmc_dev #(.N_PERIPH(16), .SETTLE_CYC(SETTLE)) u_cpmc_dev (.clock_i(clock_i),
		.srst_i(srst_i), .bus(port_if), .irc_tick_i(irc_tick_i), .sysosc_tick_i(sysosc_tick_i),
		.wdosc_tick_i(wdosc_tick_i), .irq_i(irq_i), .wake_pin_i(wake_pin_i),
		.rtc_match_i(rtc_match_i), .powerdown_exit_pin_n_i(pd_exit_n), .main_tick_o(main_tick),
		.cpu_core_clock_o(cpu_tick), .clock_output_pin_o(), .watchdog_counter_tick_o(),
		.periph_clk_en_o(pclk_en), .power_en_o(power_en), .retention_o());
	cpmc_ctl u_cpmc_ctl (.clock_i(clock_i), .srst_i(srst_i), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dev(port_if));
	cpmc_port_asserts #(.SETTLE_CYC(SETTLE)) u_cpmc_port_asserts (.clock_i(clock_i),
		.srst_i(srst_i), .req(port_if.req), .we(port_if.we), .addr(port_if.addr),
		.wdata(port_if.wdata), .ready(port_if.ready), .rdata(port_if.rdata));
	// --------------------------------
	// helpers
	// --------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic cmp_rd(input logic [31:0] d, input logic e, input cpmc_exp_t x);
		check_count++;
		if (((d & x.m) !== (x.d & x.m)) || (e !== x.e)) begin
			fail_count++;
			$display("[ERR] %0t read %h err %b, want %h err %b", $time, d, e, x.d, x.e);
		end
	endtask : cmp_rd
	task automatic cmp_out(input logic [31:0] got, input logic [31:0] want);
		check_count++;
		if (got !== want) begin
			fail_count++;
			$display("[ERR] %0t output %h, want %h", $time, got, want);
		end
	endtask : cmp_out
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
		@(posedge clock_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		chk_on <= c;
		@(posedge clock_i);
		penable <= 1'b1;
		do @(posedge clock_i); while (pready !== 1'b1);
		rv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		chk_on <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic e);
		exp_q.push_back('{d, m, e});
		apb(1'b0, a, 32'h0, 1'b1);
	endtask : rd
	task automatic cmd(input cpmc_cmd_t c);
		apb(1'b1, AO_CMD, {30'h0, c}, 1'b0);
		do apb(1'b0, AO_STATUS, 32'h0, 1'b0); while (rv[0] !== 1'b0);
	endtask : cmd
	task automatic dev_wr(input logic [3:0] a, input logic [31:0] d);
		apb(1'b1, AO_ADDR, {28'h0, a}, 1'b0);
		apb(1'b1, AO_DATA, d, 1'b0);
		cmd(CMD_WR);
	endtask : dev_wr
	task automatic dev_rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
		apb(1'b1, AO_ADDR, {28'h0, a}, 1'b0);
		cmd(CMD_RD);
		rd(AO_DATA, d, m, 1'b0);
	endtask : dev_rd
	task automatic window(output int c, output int m);
		int c0;
		int m0;
		c0 = cpu_cnt;
		m0 = main_cnt;
		repeat (200) @(posedge clock_i);
		c = cpu_cnt - c0;
		m = main_cnt - m0;
	endtask : window
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// --------------------------------
	// clock, oscillators, monitor
	// --------------------------------
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	// gaps keep every oscillator edge a lone pulse
	always @(posedge clock_i) begin
		tk <= lfsr(tk);
		irc_tick_i <= tk[0] && !irc_tick_i;
		sysosc_tick_i <= tk[4] && !sysosc_tick_i;
		wdosc_tick_i <= tk[9] && !wdosc_tick_i;
		cpu_cnt <= cpu_cnt + int'(cpu_tick === 1'b1);
		main_cnt <= main_cnt + int'(main_tick === 1'b1);
		if (psel && penable && pready && chk_on) cmp_rd(prdata, pslverr, exp_q.pop_front());
	end
	initial begin
		repeat (40000) @(posedge clock_i);
		fail_count++;
		tally_and_finish();
	end
	// --------------------------------
	// scenarios
	// --------------------------------
	initial begin
		{srst_i, psel, penable, pwrite, chk_on, irq_i, rtc_match_i} = 7'h40;
		{irc_tick_i, sysosc_tick_i, wdosc_tick_i, pd_exit_n} = 4'h1;
		{paddr, pwdata, wake_pin_i, tk} = {8'h0, 32'h0, 12'h0, 32'h2f66};
		{fail_count, check_count, cpu_cnt, main_cnt} = '0;
		repeat (8) @(posedge clock_i);
		srst_i <= 1'b0;
		cmp_out(32'(power_en), 32'h2f);
		rd(AO_STATUS, 32'h0, 32'h3, 1'b0);
		rd(8'h10, 32'h0, 32'hffffffff, 1'b1);
		dev_rd(RA_STAT, 32'h0, 32'h3f);
		dev_rd(RA_CPUDIV, 32'h1, 32'hff);
		g = lfsr(tk);
		dev_wr(RA_GATE, g);
		cmp_out(32'(pclk_en), {16'h0, g[15:0]});
		dev_wr(RA_CPUDIV, 32'h2);
		window(dc, dm);
		cmp_out(32'(unsigned'(2 * dc - dm + 2) <= 4 && dm > 8), 32'h1);
		apb(1'b1, AO_DATA, 32'h0, 1'b0);
		cmd(CMD_PLLUP);
		rd(AO_STATUS, 32'h2, 32'h3, 1'b0);
		apb(1'b1, AO_DATA, 32'h0f, 1'b0);
		cmd(CMD_PLLUP);
		rd(AO_STATUS, 32'h0, 32'h3, 1'b0);
		dev_rd(RA_STAT, 32'hd, 32'hf);
		cmp_out(32'(power_en[PW_PLL]), 32'h1);
		dev_wr(RA_PMODE, 32'h1);
		window(dc, dm);
		cmp_out(32'(dc), 32'h0);
		cmp_out(32'(dm > 8), 32'h1);
		cmp_out(32'(pclk_en), {16'h0, g[15:0]});
		irq_i <= 1'b1;
		dev_rd(RA_STAT, 32'h0, 32'h30);
		irq_i <= 1'b0;
		dev_wr(4'hc, g);
		dev_wr(RA_PMODE, 32'h3);
		pd_exit_n <= 1'b0;
		repeat (3) @(posedge clock_i);
		pd_exit_n <= 1'b1;
		dev_rd(RA_STAT, 32'h0, 32'h3d);
		dev_rd(4'hc, g, 32'hffffffff);
		dev_wr(RA_STARTEN, 32'h1);
		apb(1'b1, AO_DATA, 32'h0, 1'b0);
		cmd(CMD_DSLEEP);
		cmp_out(32'(power_en[4:0]), 32'h0);
		window(dc, dm);
		cmp_out(32'(dc), 32'h0);
		wake_pin_i <= 12'h800;
		dev_rd(RA_STAT, 32'h20, 32'h30);
		wake_pin_i <= 12'h001;
		dev_rd(RA_STAT, 32'h0, 32'h3c);
		wake_pin_i <= 12'h0;
		repeat (4) @(posedge clock_i);
		tally_and_finish();
	end
endmodule : tb_top
